// >>> core/adram_ctrl.sv
/*
 * two-block asynchronous dram decode and strobe timing engine with apb
 * registers. one cycle request port from internal masters.
 * assumes masters hold the request until done, and refresh_tick comes
 * from a refresh divider on the same clock.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - base field bits 31..18 compared with address; all unmasked equal selects block
// - mask bit one drops that address bit from decode; gaps allowed
// - refresh a block only while its refresh enable is set; clear at reset
// - column strobe held 1 to 4 clocks by two-bit length field
// - row strobe precharge 1 to 4 clocks; refresh precharge uses the same length field
// - row release bit one negates row strobe one clock before column strobe
// - release bit ignored when column strobe lasts only one clock
// - release applies only to single accesses, never later page beats
// - row to column delay is one clock, or two when delay bit set
// - extended-out bit selects extended data out timing for that block
// - port width 00 32 bit, 01 8 bit, 1x 16 bit; bus sizing follows
// - page policy 00 off, 01 bursts, 11 open; 10 reserved
// - writes to protected block not performed; address exception raised
// - protected write passed to chip select; missing acknowledge gives access fault
// - contents not kept through hard or watchdog reset; no refresh then
// - these meanings hold only while global synchronous bit is zero
// - page hit uses fixed 512 byte page
module adram_ctrl
   import adram_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic        req_burst,
   input  wire logic        req_last,
   input  wire logic [31:0] req_addr,
   output      logic        req_done,
   output      logic        req_miss,
   output      logic        addr_exc,
   output      logic        cs_write_fwd,
   input  wire logic        cs_hit,
   input  wire logic        ext_ack,
   input  wire logic        ext_timeout,
   output      logic        access_exc,
   input  wire logic        refresh_tick,
   output      logic [1:0]  ras_n,
   output      logic [1:0]  cas_n,
   output      logic        dram_we,
   output      logic        col_phase,
   output      logic [1:0]  bus_width,
   output      logic        edo_mode
);
   typedef struct packed {
      logic [31:0] cfg0;
      logic [31:0] cfg1;
      logic [31:0] mask0;
      logic [31:0] mask1;
      logic        sync_mode;
      logic [31:0] rdata;
      seq_t        st;
      logic [2:0]  cnt;
      logic        blk;
      logic        wr;
      logic        page_open;
      logic        in_page;
      logic [31:PAGE_LSB] page_tag;
      logic [1:0]  ras_n;
      logic [1:0]  cas_n;
      logic        done;
      logic        miss;
      logic        aexc;
      logic        fwd;
      logic        cexc;
      logic [1:0]  rfsh_pend;
      logic        rfsh_blk;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [1:0]  hit;
   logic [31:0] bcfg;
   logic [31:0] bmask;
   logic [1:0]  cas_len;
   logic        early_rel;
   logic        apb_acc;

   blk_decode_if d0 ();
   blk_decode_if d1 ();
   assign d0.cfg  = s_r.cfg0;
   assign d0.mask = s_r.mask0;
   assign d0.addr = req_addr;
   assign d1.cfg  = s_r.cfg1;
   assign d1.mask = s_r.mask1;
   assign d1.addr = req_addr;
   blk_decode u_dec0 (.dif(d0.decoder));
   blk_decode u_dec1 (.dif(d1.decoder));
   // block 0 wins an overlap; overlapping ranges are a software fault
   assign hit = {d1.hit & ~d0.hit, d0.hit};

   ////////////////////////////////////////////////////////////////////
   assign apb_acc = psel & penable;
   assign bcfg    = s_r.blk ? s_r.cfg1 : s_r.cfg0;
   assign bmask   = s_r.blk ? s_r.mask1 : s_r.mask0;
   assign cas_len = bcfg[CAS_LO+1:CAS_LO];
   // early release only on a single access with a multi-clock column strobe
   assign early_rel = bcfg[REL_BIT] & (cas_len != 2'h0)
                    & ~s_r.in_page;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      s_nxt.miss = 1'b0;
      s_nxt.aexc = 1'b0;
      s_nxt.cexc = 1'b0;
      if (apb_acc && pwrite) begin
         unique case (paddr)
            OFF_BLK0_CFG:  s_nxt.cfg0  = pwdata & CFG_WMASK;
            OFF_BLK1_CFG:  s_nxt.cfg1  = pwdata & CFG_WMASK;
            OFF_BLK0_MASK: s_nxt.mask0 = pwdata & MASK_WMASK;
            OFF_BLK1_MASK: s_nxt.mask1 = pwdata & MASK_WMASK;
            OFF_GLOBAL:    s_nxt.sync_mode = pwdata[SYNC_BIT];
            default:       s_nxt.rdata = s_r.rdata;
         endcase
      end
      unique case (paddr)
         OFF_BLK0_CFG:  s_nxt.rdata = s_r.cfg0;
         OFF_BLK1_CFG:  s_nxt.rdata = s_r.cfg1;
         OFF_BLK0_MASK: s_nxt.rdata = s_r.mask0;
         OFF_BLK1_MASK: s_nxt.rdata = s_r.mask1;
         OFF_GLOBAL:    s_nxt.rdata = {31'h0, s_r.sync_mode};
         OFF_STATUS:    s_nxt.rdata = {26'h0, s_r.rfsh_pend, s_r.page_open, s_r.blk,
                                       s_r.st == ST_IDLE, s_r.sync_mode};
         default:       s_nxt.rdata = 32'h00000000;
      endcase
      // refresh requests collect per block, only for enabled blocks
      if (refresh_tick) begin
         s_nxt.rfsh_pend = s_r.rfsh_pend |
            {s_r.cfg1[RFSH_BIT], s_r.cfg0[RFSH_BIT]};
      end
      if (s_r.fwd) begin
         if (ext_ack || cs_hit) begin
            s_nxt.fwd  = 1'b0;
            s_nxt.done = 1'b1;
         end else if (ext_timeout) begin
            s_nxt.fwd  = 1'b0;
            s_nxt.cexc = 1'b1;
         end
      end
      unique case (s_r.st)
         ST_IDLE: begin
            if (s_r.sync_mode) begin
               s_nxt.page_open = 1'b0;
            end else if (|s_r.rfsh_pend) begin
               s_nxt.rfsh_blk  = ~s_r.rfsh_pend[0];
               s_nxt.ras_n     = s_r.rfsh_pend[0] ? 2'b10 : 2'b01;
               s_nxt.page_open = 1'b0;
               s_nxt.cnt       = REFRESH_LEN;
               s_nxt.st        = ST_RFSH;
            end else if (req_valid && !s_r.fwd && !s_r.done) begin
               if (hit == 2'b00) begin
                  s_nxt.miss      = 1'b1;
                  s_nxt.page_open = 1'b0;
               end else if (req_write && (hit[0] ? s_r.mask0[WP_BIT]
                                                 : s_r.mask1[WP_BIT])) begin
                  s_nxt.aexc = 1'b1;
                  s_nxt.fwd  = 1'b1;
               end else begin
                  s_nxt.blk = hit[1];
                  s_nxt.wr  = req_write;
                  s_nxt.in_page = s_r.page_open && s_r.blk == hit[1]
                     && s_r.page_tag == req_addr[31:PAGE_LSB];
                  s_nxt.page_tag = req_addr[31:PAGE_LSB];
                  if (s_nxt.in_page) begin
                     s_nxt.cas_n = hit[1] ? 2'b01 : 2'b10;
                     s_nxt.cnt   = 3'h0;
                     s_nxt.st    = ST_COL;
                  end else begin
                     s_nxt.ras_n = hit[1] ? 2'b01 : 2'b10;
                     s_nxt.ras_n = s_nxt.ras_n & s_r.ras_n;
                     s_nxt.cnt   = {2'h0, (hit[1] ? s_r.cfg1[RCD_BIT]
                                                  : s_r.cfg0[RCD_BIT])};
                     s_nxt.st    = ST_ROW;
                  end
               end
            end
         end
         ST_ROW: begin
            if (s_r.cnt == 3'h0) begin
               s_nxt.cas_n = s_r.blk ? 2'b01 : 2'b10;
               s_nxt.st    = ST_COL;
            end else begin
               s_nxt.cnt = s_r.cnt - 3'h1;
            end
         end
         ST_COL: begin
            if (s_r.cnt == {1'b0, cas_len}) begin
               s_nxt.cas_n = 2'b11;
               s_nxt.done  = 1'b1;
               s_nxt.cnt   = {1'b0, bcfg[PRE_LO+1:PRE_LO]};
               if (bcfg[PP_LO+1:PP_LO] == PP_OPEN || (bcfg[PP_LO+1:PP_LO] ==
                   PP_BURST && req_burst && !req_last)) begin
                  s_nxt.page_open = 1'b1;
                  s_nxt.st        = ST_IDLE;
               end else begin
                  s_nxt.page_open = 1'b0;
                  s_nxt.ras_n     = 2'b11;
                  s_nxt.st        = ST_PRE;
               end
            end else begin
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (early_rel && s_r.cnt == {1'b0, cas_len} - 3'h1 &&
                   bcfg[PP_LO+1:PP_LO] != PP_OPEN) begin
                  s_nxt.ras_n = 2'b11;
               end
            end
         end
         ST_PRE: begin
            if (s_r.cnt == 3'h0) begin
               s_nxt.st = ST_IDLE;
            end else begin
               s_nxt.cnt = s_r.cnt - 3'h1;
            end
         end
         ST_RFSH: begin
            if (s_r.cnt == 3'h0) begin
               s_nxt.ras_n = 2'b11;
               s_nxt.rfsh_pend[s_r.rfsh_blk] = 1'b0;
               s_nxt.cnt = {1'b0, bcfg[PRE_LO+1:PRE_LO]};
               s_nxt.st  = ST_PRE;
            end else begin
               s_nxt.cnt = s_r.cnt - 3'h1;
            end
         end
         ST_HOLD: s_nxt.st = ST_IDLE;
         default: s_nxt.st = ST_IDLE;
      endcase
      if (refresh_tick && s_r.st == ST_RFSH && s_r.cnt == 3'h0) begin
         s_nxt.rfsh_pend[s_r.rfsh_blk] = s_r.rfsh_blk ? s_r.cfg1[RFSH_BIT]
                                                      : s_r.cfg0[RFSH_BIT];
      end
   end

   // every reset clears refresh enables, so stored data is lost
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_r       <= '0;
         s_r.ras_n <= 2'b11;
         s_r.cas_n <= 2'b11;
         s_r.st    <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign pready       = 1'b1;
   assign pslverr      = 1'b0;
   assign prdata       = s_r.rdata;
   assign req_done     = s_r.done;
   assign req_miss     = s_r.miss;
   assign addr_exc     = s_r.aexc;
   assign cs_write_fwd = s_r.fwd;
   assign access_exc   = s_r.cexc;
   assign ras_n        = s_r.ras_n;
   assign cas_n        = s_r.cas_n;
   assign dram_we      = s_r.wr & (s_r.st == ST_COL);
   assign col_phase    = s_r.st == ST_COL;
   assign bus_width    = bcfg[PW_LO+1:PW_LO];
   assign edo_mode     = bcfg[EDO_BIT];

   ////////////////////////////////////////////////////////////////////
   sequence col_start_s;
      $fell(|(~s_r.cas_n)) ##0 1'b1;
   endsequence
   a_cas_len_one: assert property (@(posedge core_clk) disable iff (!rstn)
      (s_r.st == ST_ROW && s_r.cnt == 3'h0 && cas_len == 2'h0)
      |=> col_phase ##1 cas_n == 2'b11)
      else $error("column strobe length wrong");
   a_rcd_wait: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(s_r.st == ST_ROW) |=> if (bcfg[RCD_BIT])
         (cas_n == 2'b11 ##1 cas_n != 2'b11) else (cas_n != 2'b11))
      else $error("row to column delay wrong");
   a_wp_block: assert property (@(posedge core_clk) disable iff (!rstn)
      addr_exc |-> s_r.st == ST_IDLE && cs_write_fwd)
      else $error("protected write reached dram");
   a_rfsh_gate: assert property (@(posedge core_clk) disable iff (!rstn)
      (s_r.st != ST_RFSH) ##1 (s_r.st == ST_RFSH)
      |-> (s_r.rfsh_blk ? s_r.cfg1[RFSH_BIT] : s_r.cfg0[RFSH_BIT])
          || $past(refresh_tick))
      else $error("refresh to disabled block");
   a_sync_idle: assert property (@(posedge core_clk) disable iff (!rstn)
      (s_r.sync_mode && s_r.st == ST_IDLE) |=> s_r.st == ST_IDLE)
      else $error("access started in synchronous mode");
   a_prech_len: assert property (@(posedge core_clk) disable iff (!rstn)
      ($rose(s_r.st == ST_PRE) && s_r.cnt == 3'h0) |=> s_r.st == ST_IDLE)
      else $error("precharge length wrong");
   a_miss_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      req_miss |-> ras_n == $past(ras_n) || s_r.st != ST_IDLE)
      else $error("miss drove row strobe");
   a_access_fault: assert property (@(posedge core_clk) disable iff (!rstn)
      (cs_write_fwd && ext_timeout && !ext_ack && !cs_hit) |=> access_exc)
      else $error("unacknowledged forward not faulted");
endmodule : adram_ctrl

// >>> core/adram_pkg.sv
/*
 * constants, register layout and types for the asynchronous dram block
 * decode and timing engine.
 * assumes a single 200 MHz clock and an apb register port.
 */
package adram_pkg;
   localparam logic [11:0] OFF_BLK0_CFG  = 12'h000;
   localparam logic [11:0] OFF_BLK1_CFG  = 12'h004;
   localparam logic [11:0] OFF_BLK0_MASK = 12'h008;
   localparam logic [11:0] OFF_BLK1_MASK = 12'h00C;
   localparam logic [11:0] OFF_GLOBAL    = 12'h010;
   localparam logic [11:0] OFF_STATUS    = 12'h014;
   localparam logic [31:0] CFG_WMASK     = 32'hFFFCBF7C;
   localparam logic [31:0] MASK_WMASK    = 32'hFFFC0100;
   localparam logic [31:0] CFG_RESET     = 32'h00000000;
   localparam logic [31:0] MASK_RESET    = 32'h00000000;
   localparam int BASE_HI   = 31;
   localparam int BASE_LO   = 18;
   localparam int RFSH_BIT  = 15;
   localparam int CAS_LO    = 12;
   localparam int PRE_LO    = 10;
   localparam int REL_BIT   = 9;
   localparam int RCD_BIT   = 8;
   localparam int WP_BIT    = 8;
   localparam int EDO_BIT   = 6;
   localparam int PW_LO     = 4;
   localparam int PP_LO     = 2;
   localparam int SYNC_BIT  = 0;
   localparam int PAGE_BYTES = 512;
   localparam int PAGE_LSB   = $clog2(PAGE_BYTES);
   localparam logic [1:0] PW_32 = 2'h0;
   localparam logic [1:0] PW_8  = 2'h1;
   localparam logic [1:0] PP_OFF   = 2'h0;
   localparam logic [1:0] PP_BURST = 2'h1;
   localparam logic [1:0] PP_OPEN  = 2'h3;
   localparam logic [2:0] REFRESH_LEN = 3'h2;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ROW, ST_COL, ST_HOLD, ST_PRE, ST_RFSH
   } seq_t;
endpackage : adram_pkg

// >>> core/blk_decode.sv
/*
 * address hit decode for one dram block.
 * assumes the address is stable for the cycle in which hit is read.
 */
`timescale 1ns/1ps
module blk_decode
   import adram_pkg::*;
(
   blk_decode_if.decoder dif
);
   logic [BASE_HI-BASE_LO:0] diff;
   always_comb begin
      diff = dif.cfg[BASE_HI:BASE_LO] ^ dif.addr[BASE_HI:BASE_LO];
   end
   assign dif.hit = ~|(diff & ~dif.mask[BASE_HI:BASE_LO]);
endmodule : blk_decode

// >>> core/blk_decode_if.sv
/*
 * carries one block's settings into its decoder and the hit back.
 * assumes the decoder and the engine share core_clk.
 */
`timescale 1ns/1ps
interface blk_decode_if;
   logic [31:0] cfg;
   logic [31:0] mask;
   logic [31:0] addr;
   logic        hit;
   modport engine (output cfg, output mask, output addr, input hit);
   modport decoder (input cfg, input mask, input addr, output hit);
endinterface : blk_decode_if

// >>> verif/adram_ctrl_bench.sv
/*
 * self-checking bench for adram_ctrl: apb register tasks and master requests.
 * assumes the zero-wait apb slave and request contract of the design.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module adram_ctrl_bench;
   import adram_pkg::*;
   logic        core_clk = 1'b0, rstn = 1'b0;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, req_done, req_miss, addr_exc, cs_write_fwd, access_exc;
   logic        req_valid = 0, req_write = 0, req_burst = 0, req_last = 0;
   logic [31:0] req_addr = 32'h0;
   logic        cs_hit = 0, ext_ack = 0, ext_timeout = 0, refresh_tick = 0;
   logic [1:0]  ras_n, cas_n, bus_width, blk, bw;
   logic        dram_we, col_phase, edo_mode, ed, we;
   logic [3:0]  cas_len, rc_len;
   logic        ras_first;
   int          err_count = 0, num_checks = 0, res, n;
   always #2.5 core_clk = ~core_clk;
   adram_ctrl i_adram_ctrl (.core_clk(core_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
      .req_write(req_write), .req_burst(req_burst), .req_last(req_last),
      .req_addr(req_addr), .req_done(req_done), .req_miss(req_miss),
      .addr_exc(addr_exc), .cs_write_fwd(cs_write_fwd), .cs_hit(cs_hit),
      .ext_ack(ext_ack), .ext_timeout(ext_timeout), .access_exc(access_exc),
      .refresh_tick(refresh_tick), .ras_n(ras_n), .cas_n(cas_n), .dram_we(dram_we),
      .col_phase(col_phase), .bus_width(bus_width), .edo_mode(edo_mode));
   dram_model #(.EDO_OK(1'b1)) i_dram_model (.core_clk(core_clk), .rstn(rstn),
      .ras_n(ras_n), .cas_n(cas_n), .cas_len(cas_len), .rc_len(rc_len),
      .ras_first(ras_first));
   ////////////////////////////////////////////////////////////////
   task summarize;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      psel <= 0; penable <= 0;
      if (i == 20) begin err_count++; summarize(); end
   endtask : apb
   // res: 0 no answer, 1 done, 2 miss, 3 address exception
   task run(input logic [31:0] a, input logic w);
      int i;
      @(posedge core_clk);
      req_valid <= 1; req_addr <= a; req_write <= w;
      res = 0; blk = 2'h0;
      for (i = 0; i < 60 && res == 0; i++) begin
         @(posedge core_clk);
         #1;
         blk |= ~ras_n;
         if (cas_n != 2'h3) begin bw = bus_width; ed = edo_mode; we = dram_we; end
         res = req_done ? 1 : req_miss ? 2 : addr_exc ? 3 : 0;
      end
      // held through the answer edge, released on the next one
      @(posedge core_clk) req_valid <= 0;
      #1;
   endtask : run
   task wait_on(input int k);
      int i;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         #1;
         if ((k == 0 && cs_write_fwd) || (k == 1 && access_exc) || (k == 2 && req_done))
            break;
      end
      `CHK("fwd wait", 1, i < 40)
   endtask : wait_on
   task tick_count;
      @(posedge core_clk) refresh_tick <= 1;
      @(posedge core_clk) refresh_tick <= 0;
      n = 0;
      repeat (30) begin @(posedge core_clk); #1; n += (ras_n != 2'h3); end
   endtask : tick_count
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1;
      for (int k = 0; k < 5; k++) begin
         apb(0, 12'h004 * k[11:0] + (k == 4 ? 12'h004 : 12'h000), 0);
         // status shows the idle bit after reset
         `CHK("reset reg", (k == 4 ? 32'h00000002 : 32'h00000000), rd)
      end
      // timing codes, release bit set for the one and two clock cases
      for (int c = 0; c < 4; c++) for (int r = 0; r < 2; r++) begin
         apb(1, OFF_BLK0_CFG, (c << 12) | (r << 8) | ((c < 2) << 9));
         run(32'h0000_0100, 0);
         `CHK("done", 1, res)
         `CHK("read strobe", 0, we)
         `CHK("cas width", c + 1, cas_len)
         `CHK("row to col", r + 1, rc_len)
         `CHK("early row", (c == 1), ras_first)
      end
      for (int p = 0; p < 4; p++) begin
         apb(1, OFF_BLK0_CFG, (p << 4) | ((p == 3) << 6)
            | ((p == 1 ? 1 : p == 2 ? 3 : 0) << 2));
         run(32'h0000_0200, 0);
         `CHK("width", {p == 0, p == 1}, {bw == PW_32, bw == PW_8})
         `CHK("edo", (p == 3), ed)
      end
      apb(1, OFF_BLK1_CFG, 32'h4000_0000);
      apb(1, OFF_BLK1_MASK, 32'h0010_0000);
      run(32'h4010_0000, 1);
      `CHK("masked hit", 2'h2, blk)
      `CHK("write strobe", 1, we)
      run(32'h4008_0000, 0);
      `CHK("unmasked miss", 2, res)
      apb(1, OFF_BLK0_MASK, 32'h0000_0100);
      for (int k = 0; k < 2; k++) begin
         run(32'h0000_0100, 1);
         `CHK("protect", 3, res)
         `CHK("no strobe", 2'h0, blk)
         wait_on(0);
         @(posedge core_clk) begin ext_timeout <= (k == 0); cs_hit <= (k == 1); end
         wait_on(k + 1);
         @(posedge core_clk) begin ext_timeout <= 0; cs_hit <= 0; end
      end
      apb(1, OFF_BLK0_CFG, 32'h0);
      tick_count();
      `CHK("no refresh", 0, n)
      apb(1, OFF_BLK0_CFG, 32'h0000_8000);
      tick_count();
      `CHK("refresh", 1, n > 0)
      apb(1, OFF_GLOBAL, 32'h1);
      run(32'h0000_0100, 0);
      `CHK("sync refused", 0, res)
      apb(1, OFF_GLOBAL, 32'h0);
      @(posedge core_clk) rstn <= 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1;
      apb(0, OFF_BLK0_CFG, 0);
      `CHK("reset clears", 32'h0, rd)
      summarize();
   end
endmodule : adram_ctrl_bench

// >>> verif/dram_model.sv
/*
 * behavioural far-side dram: measures strobe widths and order.
 * assumes registered active low strobes on core_clk.
 */
`timescale 1ns/1ps
module dram_model #(
   parameter bit EDO_OK = 1'b1
) (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic [1:0] ras_n,
   input  wire logic [1:0] cas_n,
   output      logic [3:0] cas_len,
   output      logic [3:0] rc_len,
   output      logic       ras_first
);
   logic [3:0] cnt;
   logic [3:0] rc_cnt;
   logic       cas_was;
   logic       ras_hi;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt       <= 4'h0;
         rc_cnt    <= 4'h0;
         cas_was   <= 1'b0;
         ras_hi    <= 1'b0;
         cas_len   <= 4'h0;
         rc_len    <= 4'h0;
         ras_first <= 1'b0;
      end else begin
         cas_was <= (cas_n != 2'h3);
         if (cas_n != 2'h3) begin
            cnt    <= cnt + 4'h1;
            ras_hi <= (ras_n == 2'h3);
            if (!cas_was) rc_len <= rc_cnt;
         end else if (cas_was) begin
            // latch widths once the column strobe is released
            cas_len   <= cnt;
            ras_first <= ras_hi;
            cnt       <= 4'h0;
         end
         if (ras_n == 2'h3) rc_cnt <= 4'h0;
         else if (cas_n == 2'h3) rc_cnt <= rc_cnt + 4'h1;
      end
   end
endmodule : dram_model
